/* hdl/scr_pkg.sv */
// Purpose : shared constants and types for the synthesizer config registers
// Assumes : byte-wide management register port, one 125 MHz clock
// Notes   : multi-byte registers place the most significant byte first
//
// How it works
// - fourth synth runs at base value times multiple times eight, unsigned.
// - that product is further scaled by numerator over denominator of ratio.
// - ratio register: denominator in 15:0, numerator in 31:16, resets one-to-one.
// - two-bit field picks which of four PLLs drives the first synthesizer.
// - same PLL-select coding for synths two to four in bits 3:2, 5:4, 7:6.
// - enable bit n turns on output of synthesizer n; cleared bit disables it.
// - per-PLL lock criterion: 01 1us/1s, 10 10us/1s, 11 10us/10s, 00 reserved.
package scr_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] SCR_ADDR_MULT_HI  = 7'h6A;
  localparam logic [6:0] SCR_ADDR_MULT_LO  = 7'h6B;
  localparam logic [6:0] SCR_ADDR_RATIO_B3 = 7'h6C;
  localparam logic [6:0] SCR_ADDR_RATIO_B2 = 7'h6D;
  localparam logic [6:0] SCR_ADDR_RATIO_B1 = 7'h6E;
  localparam logic [6:0] SCR_ADDR_RATIO_B0 = 7'h6F;
  localparam logic [6:0] SCR_ADDR_ROUTING  = 7'h70;
  localparam logic [6:0] SCR_ADDR_OUT_EN   = 7'h71;
  localparam logic [6:0] SCR_ADDR_LOCK     = 7'h72;

  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [15:0] SCR_RST_MULT    = 16'h0798;
  localparam logic [31:0] SCR_RST_RATIO   = 32'h0001_0001;
  localparam logic [7:0]  SCR_RST_ROUTING = 8'hE4;
  localparam logic [7:0]  SCR_RST_OUT_EN  = 8'h03;
  localparam logic [7:0]  SCR_RST_LOCK    = 8'hAA;
  localparam int          SCR_DEN_LSB     = 0;
  localparam int          SCR_NUM_LSB     = 16;
  localparam int          SCR_SEL_W       = 2;
  localparam int          SCR_EN_W        = 4;
  localparam int          SCR_NUM_SYNTH   = 4;
  localparam int          SCR_NUM_PLL     = 4;
  localparam logic [2:0]  SCR_MULT_SHIFT  = 3'h0; // times eight = three zeros

  // ----------------------------------------------------------------
  // lock criterion decode and frequency limits
  // ----------------------------------------------------------------
  localparam logic [1:0] SCR_LOCK_RSVD   = 2'h0;
  localparam logic [1:0] SCR_LOCK_1US_1S = 2'h1;
  localparam logic [1:0] SCR_LOCK_10US_1S = 2'h2;
  localparam logic [3:0] SCR_LIMIT_FINE_US = 4'h1;
  localparam logic [3:0] SCR_LIMIT_WIDE_US = 4'hA;
  localparam logic [3:0] SCR_HOLD_SHORT_S  = 4'h1;
  localparam logic [3:0] SCR_HOLD_LONG_S   = 4'hA;
  localparam logic [50:0] SCR_FREQ_MIN_HZ  = 51'h0_0000_1DCD_6500;

  localparam int SCR_DIVD_W = 51;
  localparam int SCR_DIVS_W = 16;

  // management port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } scr_req_t;

endpackage

/* hdl/scr_divider.sv */
// Purpose : unsigned restoring divider, one quotient bit per clock
// Assumes : start only while idle; operands sampled at start
// Notes   : a zero divisor yields an all-ones quotient
`timescale 1ns/1ps
module scr_divider
  import scr_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  start,
  input  wire logic [SCR_DIVD_W-1:0] dividend,
  input  wire logic [SCR_DIVS_W-1:0] divisor,
  output logic                       busy,
  output logic                       done,
  output logic [SCR_DIVD_W-1:0]      quotient
);

  logic [SCR_DIVS_W:0]   rem;
  logic [SCR_DIVS_W-1:0] den;
  logic [5:0]            cnt;

  // ----------------------------------------------------------------
  // one restoring step
  // ----------------------------------------------------------------
  wire logic [SCR_DIVS_W:0] shifted = {rem[SCR_DIVS_W-1:0],
                                       quotient[SCR_DIVD_W-1]};
  wire logic                fits    = shifted >= {1'b0, den};
  wire logic [SCR_DIVS_W:0] next_rem =
    fits ? shifted - {1'b0, den} : shifted;
  wire logic                last    = cnt == 6'(SCR_DIVD_W - 1);

  // quotient shifts in where the dividend shifts out
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rem      <= '0;
      den      <= '0;
      cnt      <= '0;
      busy     <= 1'b0;
      done     <= 1'b0;
      quotient <= '0;
    end
    else if (start && !busy)
    begin
      rem      <= '0;
      den      <= divisor;
      cnt      <= '0;
      busy     <= 1'b1;
      done     <= 1'b0;
      quotient <= dividend;
    end
    else
    begin
      done <= busy && last;
      if (busy)
      begin
        rem      <= next_rem;
        quotient <= {quotient[SCR_DIVD_W-2:0], fits};
        cnt      <= cnt + 6'h01;
        busy     <= !last;
      end
    end
  end

endmodule

/* hdl/scr_regs.sv */
// Purpose : synthesizer routing, enable, lock criterion and fourth synth
//           frequency configuration registers
// Assumes : byte register port already decoded from the serial interface
// Notes   : frequency output trails a register change by about 53 clocks
`timescale 1ns/1ps
module scr_regs
  import scr_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire scr_req_t              reg_req,
  output logic [7:0]                 reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic [15:0]           base_frequency_value,
  output logic [SCR_NUM_SYNTH*SCR_SEL_W-1:0] synth_pll_select,
  output logic [SCR_EN_W-1:0]        synth_out_enable,
  output logic [SCR_NUM_PLL*2-1:0]   pll_lock_code,
  output logic [SCR_NUM_PLL*4-1:0]   pll_lock_limit_us,
  output logic [SCR_NUM_PLL*4-1:0]   pll_lock_hold_s,
  output logic [SCR_NUM_PLL-1:0]     pll_lock_code_reserved,
  output logic [SCR_DIVD_W-1:0]      fourth_synth_freq_hz,
  output logic                       fourth_synth_freq_valid,
  output logic                       fourth_synth_below_min,
  output logic                       fourth_synth_ratio_zero
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [15:0] synth3_base_multiple;
  logic [31:0] synth3_ratio_num_den;
  logic [7:0]  synth_pll_routing;
  logic [3:0]  synth_enable_bits;
  logic [7:0]  pll_lock_criterion;

  wire logic [15:0] fourth_synth_multiple_field = synth3_base_multiple;
  wire logic [15:0] fourth_synth_ratio_denominator =
    synth3_ratio_num_den[SCR_DEN_LSB +: 16];
  wire logic [15:0] fourth_synth_ratio_numerator =
    synth3_ratio_num_den[SCR_NUM_LSB +: 16];

  // reserved upper enable nibble is not stored, so it reads as reset
  wire logic [7:0] synth_output_enable =
    {SCR_RST_OUT_EN[7:4], synth_enable_bits};

  // write strobes per byte address
  wire logic wr_mult_hi = reg_req.wr && reg_req.addr == SCR_ADDR_MULT_HI;
  wire logic wr_mult_lo = reg_req.wr && reg_req.addr == SCR_ADDR_MULT_LO;
  wire logic wr_r3 = reg_req.wr && reg_req.addr == SCR_ADDR_RATIO_B3;
  wire logic wr_r2 = reg_req.wr && reg_req.addr == SCR_ADDR_RATIO_B2;
  wire logic wr_r1 = reg_req.wr && reg_req.addr == SCR_ADDR_RATIO_B1;
  wire logic wr_r0 = reg_req.wr && reg_req.addr == SCR_ADDR_RATIO_B0;
  wire logic wr_route = reg_req.wr && reg_req.addr == SCR_ADDR_ROUTING;
  wire logic wr_en    = reg_req.wr && reg_req.addr == SCR_ADDR_OUT_EN;
  wire logic wr_lock  = reg_req.wr && reg_req.addr == SCR_ADDR_LOCK;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      synth3_base_multiple <= SCR_RST_MULT;
      synth3_ratio_num_den <= SCR_RST_RATIO;
      synth_pll_routing    <= SCR_RST_ROUTING;
      synth_enable_bits    <= SCR_RST_OUT_EN[3:0];
      pll_lock_criterion   <= SCR_RST_LOCK;
    end
    else
    begin
      if (wr_mult_hi) synth3_base_multiple[15:8] <= reg_req.wdata;
      if (wr_mult_lo) synth3_base_multiple[7:0]  <= reg_req.wdata;
      if (wr_r3) synth3_ratio_num_den[31:24] <= reg_req.wdata;
      if (wr_r2) synth3_ratio_num_den[23:16] <= reg_req.wdata;
      if (wr_r1) synth3_ratio_num_den[15:8]  <= reg_req.wdata;
      if (wr_r0) synth3_ratio_num_den[7:0]   <= reg_req.wdata;
      if (wr_route) synth_pll_routing <= reg_req.wdata;
      if (wr_en) synth_enable_bits <= reg_req.wdata[3:0];
      if (wr_lock) pll_lock_criterion <= reg_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  // unmapped addresses read zero
  wire logic [6:0] ra = reg_req.addr;
  wire logic [7:0] next_rdata =
    ra == SCR_ADDR_MULT_HI  ? synth3_base_multiple[15:8] :
    ra == SCR_ADDR_MULT_LO  ? synth3_base_multiple[7:0]  :
    ra == SCR_ADDR_RATIO_B3 ? synth3_ratio_num_den[31:24] :
    ra == SCR_ADDR_RATIO_B2 ? synth3_ratio_num_den[23:16] :
    ra == SCR_ADDR_RATIO_B1 ? synth3_ratio_num_den[15:8]  :
    ra == SCR_ADDR_RATIO_B0 ? synth3_ratio_num_den[7:0]   :
    ra == SCR_ADDR_ROUTING  ? synth_pll_routing :
    ra == SCR_ADDR_OUT_EN   ? synth_output_enable :
    ra == SCR_ADDR_LOCK     ? pll_lock_criterion : 8'h00;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // routing, enables and lock criterion decode
  // ----------------------------------------------------------------
  // code n in each two-bit slot selects PLL n, passed straight through
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      synth_pll_select <= SCR_RST_ROUTING;
      synth_out_enable <= SCR_RST_OUT_EN[3:0];
      pll_lock_code    <= SCR_RST_LOCK;
    end
    else
    begin
      synth_pll_select <= synth_pll_routing;
      synth_out_enable <= synth_enable_bits;
      pll_lock_code    <= pll_lock_criterion;
    end
  end

  // one decoder per PLL; reserved code reports no criterion at all
  wire logic [SCR_NUM_PLL*4-1:0] next_lock_limit_us;
  wire logic [SCR_NUM_PLL*4-1:0] next_lock_hold_s;
  wire logic [SCR_NUM_PLL-1:0]   next_lock_reserved;
  genvar g;
  generate
    for (g = 0; g < SCR_NUM_PLL; g++)
    begin : g_lock
      wire logic [1:0] code = pll_lock_criterion[2*g +: 2];
      wire logic       rsvd = code == SCR_LOCK_RSVD;
      assign next_lock_reserved[g] = rsvd;
      assign next_lock_limit_us[4*g +: 4] = rsvd ? 4'h0 :
        code == SCR_LOCK_1US_1S ? SCR_LIMIT_FINE_US : SCR_LIMIT_WIDE_US;
      assign next_lock_hold_s[4*g +: 4] = rsvd ? 4'h0 :
        (code == SCR_LOCK_1US_1S || code == SCR_LOCK_10US_1S) ?
        SCR_HOLD_SHORT_S : SCR_HOLD_LONG_S;
    end
  endgenerate

  // one process owns all lanes, so each output has a single driver
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pll_lock_limit_us      <= {SCR_NUM_PLL{SCR_LIMIT_WIDE_US}};
      pll_lock_hold_s        <= {SCR_NUM_PLL{SCR_HOLD_SHORT_S}};
      pll_lock_code_reserved <= '0;
    end
    else
    begin
      pll_lock_limit_us      <= next_lock_limit_us;
      pll_lock_hold_s        <= next_lock_hold_s;
      pll_lock_code_reserved <= next_lock_reserved;
    end
  end

  // ----------------------------------------------------------------
  // fourth synthesizer frequency
  // ----------------------------------------------------------------
  // the product stays exact in 51 bits, so no rounding before division
  wire logic [31:0] prod_bk =
    32'(base_frequency_value) * 32'(fourth_synth_multiple_field);
  wire logic [47:0] prod_bkm =
    48'(prod_bk) * 48'(fourth_synth_ratio_numerator);
  wire logic [SCR_DIVD_W-1:0] freq_dividend =
    {prod_bkm, SCR_MULT_SHIFT};

  logic [SCR_DIVD_W-1:0] last_dividend;
  logic [15:0]           last_divisor;
  logic                  have_result;
  logic                  div_busy;
  logic                  div_done;
  logic [SCR_DIVD_W-1:0] div_quotient;

  // a change mid-division is caught on the next pass, never lost
  wire logic settings_changed = !have_result ||
    freq_dividend != last_dividend ||
    fourth_synth_ratio_denominator != last_divisor;
  wire logic div_start = settings_changed && !div_busy && !div_done;

  scr_divider u_div
  (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (div_start),
    .dividend (freq_dividend),
    .divisor  (fourth_synth_ratio_denominator),
    .busy     (div_busy),
    .done     (div_done),
    .quotient (div_quotient)
  );

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      last_dividend           <= '0;
      last_divisor            <= 16'h0000;
      have_result             <= 1'b0;
      fourth_synth_freq_hz    <= '0;
      fourth_synth_freq_valid <= 1'b0;
      fourth_synth_below_min  <= 1'b0;
      fourth_synth_ratio_zero <= 1'b0;
    end
    else
    begin
      if (div_start)
      begin
        last_dividend           <= freq_dividend;
        last_divisor            <= fourth_synth_ratio_denominator;
        have_result             <= 1'b1;
        fourth_synth_freq_valid <= 1'b0;
      end
      if (div_done)
      begin
        fourth_synth_freq_hz    <= div_quotient;
        fourth_synth_freq_valid <= !settings_changed;
        // host owns the range; flag only as a status aid
        fourth_synth_below_min  <= div_quotient < SCR_FREQ_MIN_HZ;
        fourth_synth_ratio_zero <= last_divisor == 16'h0000;
      end
    end
  end

endmodule

/* testbench/scr_regs_monitor.sv */
// Purpose : port-level checks for the synthesizer config registers
// Assumes : one clock, synchronous active-high reset
// Notes   : bound into scr_regs after the module
`timescale 1ns/1ps
module scr_regs_monitor
  import scr_pkg::*;
(
  input wire logic                             clk,
  input wire logic                             sys_rst,
  input wire scr_req_t                         reg_req,
  input wire logic [7:0]                       reg_rdata,
  input wire logic                             reg_rvalid,
  input wire logic [15:0]                      base_frequency_value,
  input wire logic [SCR_NUM_SYNTH*SCR_SEL_W-1:0] synth_pll_select,
  input wire logic [SCR_EN_W-1:0]              synth_out_enable,
  input wire logic [SCR_NUM_PLL*2-1:0]         pll_lock_code,
  input wire logic [SCR_NUM_PLL*4-1:0]         pll_lock_limit_us,
  input wire logic [SCR_NUM_PLL*4-1:0]         pll_lock_hold_s,
  input wire logic [SCR_NUM_PLL-1:0]           pll_lock_code_reserved,
  input wire logic [SCR_DIVD_W-1:0]            fourth_synth_freq_hz,
  input wire logic                             fourth_synth_freq_valid,
  input wire logic                             fourth_synth_below_min,
  input wire logic                             fourth_synth_ratio_zero
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // register port steps
  // ----------------------------------------------------------------
  sequence s_wr(logic [6:0] a);
    reg_req.wr && reg_req.addr == a;
  endsequence
  sequence s_rd(logic [6:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence
  // decoded outputs land one cycle after storage, so compare two back
  a_rd_answers: assert property (reg_req.rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_req.rd))) else $error("read answer missing");
  a_route_lands: assert property (s_wr(SCR_ADDR_ROUTING) |=> ##1 synth_pll_select == $past(reg_req.wdata, 2)) else $error("routing not applied");
  a_en_lands: assert property (s_wr(SCR_ADDR_OUT_EN) |=> ##1 synth_out_enable == $past(reg_req.wdata[3:0], 2)) else $error("enable not applied");
  a_en_high_zero: assert property (s_rd(SCR_ADDR_OUT_EN) |=> reg_rdata[7:4] == 4'h0) else $error("upper enable bits not zero");
  a_rd_route: assert property (s_rd(SCR_ADDR_ROUTING) |=> reg_rdata == synth_pll_select) else $error("routing read back differs");
  // lock criterion decode, one code per pll lane
  a_lock_fine: assert property (pll_lock_code[1:0] == 2'h1 |-> pll_lock_limit_us[3:0] == 4'h1 && pll_lock_hold_s[3:0] == 4'h1) else $error("lock code 01 decode");
  a_lock_wide: assert property (pll_lock_code[3:2] == 2'h2 |-> pll_lock_limit_us[7:4] == 4'hA && pll_lock_hold_s[7:4] == 4'h1) else $error("lock code 10 decode");
  a_lock_rsvd: assert property (pll_lock_code[5:4] == 2'h0 |-> pll_lock_code_reserved[2] && pll_lock_limit_us[11:8] == 4'h0) else $error("lock code 00 decode");
  a_lock_long: assert property (pll_lock_code[7:6] == 2'h3 |-> pll_lock_limit_us[15:12] == 4'hA && pll_lock_hold_s[15:12] == 4'hA) else $error("lock code 11 decode");
  // a stuck divider would leave valid low for good
  a_freq_returns: assert property ($fell(fourth_synth_freq_valid) |-> ##[50:200] fourth_synth_freq_valid) else $error("frequency never revalidated");
  a_min_flag: assert property (fourth_synth_freq_valid |-> fourth_synth_below_min == (fourth_synth_freq_hz < SCR_FREQ_MIN_HZ)) else $error("below minimum flag wrong");
endmodule
bind scr_regs scr_regs_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .base_frequency_value(base_frequency_value),
  .synth_pll_select(synth_pll_select), .synth_out_enable(synth_out_enable),
  .pll_lock_code(pll_lock_code), .pll_lock_limit_us(pll_lock_limit_us),
  .pll_lock_hold_s(pll_lock_hold_s),
  .pll_lock_code_reserved(pll_lock_code_reserved),
  .fourth_synth_freq_hz(fourth_synth_freq_hz),
  .fourth_synth_freq_valid(fourth_synth_freq_valid),
  .fourth_synth_below_min(fourth_synth_below_min),
  .fourth_synth_ratio_zero(fourth_synth_ratio_zero));

/* testbench/tb_synth_config_registers.sv */
// Purpose : self-checking bench for the synthesizer config registers
// Assumes : byte register port, 125 MHz clock
// Notes   : expectations come from package reset values and arithmetic
`timescale 1ns/1ps
module tb_synth_config_registers
  import scr_pkg::*;
;
  logic        clk;
  logic        sys_rst;
  scr_req_t    reg_req;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [15:0] base_frequency_value;
  logic [7:0]  synth_pll_select;
  logic [3:0]  synth_out_enable;
  logic [7:0]  pll_lock_code;
  logic [15:0] pll_lock_limit_us;
  logic [15:0] pll_lock_hold_s;
  logic [3:0]  pll_lock_code_reserved;
  logic [50:0] fourth_synth_freq_hz;
  logic        fourth_synth_freq_valid;
  logic        fourth_synth_below_min;
  logic        fourth_synth_ratio_zero;
  int          n_fail;
  int          compares;
  int          cycles;

  scr_regs DUT (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .base_frequency_value(base_frequency_value),
    .synth_pll_select(synth_pll_select), .synth_out_enable(synth_out_enable),
    .pll_lock_code(pll_lock_code), .pll_lock_limit_us(pll_lock_limit_us),
    .pll_lock_hold_s(pll_lock_hold_s),
    .pll_lock_code_reserved(pll_lock_code_reserved),
    .fourth_synth_freq_hz(fourth_synth_freq_hz),
    .fourth_synth_freq_valid(fourth_synth_freq_valid),
    .fourth_synth_below_min(fourth_synth_below_min),
    .fourth_synth_ratio_zero(fourth_synth_ratio_zero));

  // ----------------------------------------------------------------
  // clock, timeout and common tasks
  // ----------------------------------------------------------------
  always #4 clk = ~clk;
  // ceiling is far above the under two thousand cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // write strobe held high across bytes, so multi-byte writes are back to back
  task automatic wr_bytes(input logic [6:0] a, input logic [31:0] d,
                          input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      reg_req <= '{1'b1, 1'b0, a + 7'(i), d[8*(n-1-i) +: 8]};
    end
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    chk(reg_rvalid, 1'b1);
    d = reg_rdata;
    @(posedge clk);
    #1;
    chk(reg_rvalid, 1'b0);
  endtask
  // every lane gets a different code; over k = 0..3 each lane sees all four
  function automatic logic [7:0] rot(input int k);
    return {2'((k+3)%4), 2'((k+2)%4), 2'((k+1)%4), 2'(k%4)};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [71:0] rv;
    logic [7:0]  d;
    rv = {SCR_RST_MULT, SCR_RST_RATIO, SCR_RST_ROUTING, SCR_RST_OUT_EN,
          SCR_RST_LOCK};
    chk(synth_pll_select, SCR_RST_ROUTING);
    chk(synth_out_enable, SCR_RST_OUT_EN);
    chk(pll_lock_code, SCR_RST_LOCK);
    for (int i = 0; i < 9; i++)
    begin
      rd_reg(SCR_ADDR_MULT_HI + 7'(i), d);
      chk(d, rv[8*(8-i) +: 8]);
    end
    wr_bytes(7'h7F, 32'h5A, 1);
    rd_reg(7'h7F, d);
    chk(d, 8'h00);
  endtask
  task automatic t_route();
    logic [7:0] d;
    for (int k = 0; k < 4; k++)
    begin
      wr_bytes(SCR_ADDR_ROUTING, 32'(rot(k)), 1);
      @(posedge clk);
      #1;
      for (int n = 0; n < 4; n++)
        chk(synth_pll_select[2*n +: 2], (n+k)%4);
      rd_reg(SCR_ADDR_ROUTING, d);
      chk(d, rot(k));
    end
  endtask
  task automatic t_enable();
    logic [7:0] v[2];
    logic [7:0] d;
    v = '{8'hF5, 8'h0A};
    for (int i = 0; i < 2; i++)
    begin
      wr_bytes(SCR_ADDR_OUT_EN, 32'(v[i]), 1);
      @(posedge clk);
      #1;
      chk(synth_out_enable, v[i][3:0]);
      rd_reg(SCR_ADDR_OUT_EN, d);
      chk(d, {4'h0, v[i][3:0]});
    end
  endtask
  task automatic t_lock();
    int c;
    for (int k = 0; k < 4; k++)
    begin
      wr_bytes(SCR_ADDR_LOCK, 32'(rot(k)), 1);
      @(posedge clk);
      #1;
      chk(pll_lock_code, rot(k));
      for (int n = 0; n < 4; n++)
      begin
        c = (n+k)%4;
        chk(pll_lock_limit_us[4*n +: 4], c == 0 ? 0 : (c == 1 ? 1 : 10));
        chk(pll_lock_hold_s[4*n +: 4], c == 3 ? 10 : (c == 0 ? 0 : 1));
        chk(pll_lock_code_reserved[n], c == 0);
      end
    end
  endtask
  task automatic t_freq(input logic [15:0] bs, input logic [15:0] k,
                        input logic [15:0] m, input logic [15:0] n);
    logic [63:0] e;
    @(posedge clk);
    base_frequency_value <= bs;
    wr_bytes(SCR_ADDR_MULT_HI, {16'h0, k}, 2);
    wr_bytes(SCR_ADDR_RATIO_B3, {m, n}, 4);
    repeat (3) @(posedge clk);
    #1;
    for (int i = 0; i < 300 && fourth_synth_freq_valid !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    e = (n == 0) ? (64'h1 << 51) - 64'h1
                 : (64'(bs) * 64'(k) * 64'h8 * 64'(m)) / 64'(n);
    chk(fourth_synth_freq_valid, 1'b1);
    chk(fourth_synth_freq_hz, e);
    chk(fourth_synth_below_min, e < 64'd500000000);
    chk(fourth_synth_ratio_zero, n == 0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    reg_req = '0;
    base_frequency_value = 16'h9C40;
    n_fail = 0;
    compares = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_route();
    t_enable();
    t_lock();
    t_freq(16'h9C40, 16'h0798, 16'h0001, 16'h0001);
    t_freq(16'h9C40, 16'h0798, 16'h00FF, 16'h00ED);
    t_freq(16'h61A8, 16'h0C35, 16'h41BE, 16'h3B80);
    t_freq(16'h9C40, 16'h0001, 16'h0001, 16'h0001);
    t_freq(16'h9C40, 16'h0798, 16'h0001, 16'h0000);
    close_out();
  end
endmodule
